// ==== rtl/dpo_position_out.sv ====
`timescale 1ns/10ps
// Behaviour
// - resolution codes 0..6, default millimetre
// - free mode divides by stored step
// - operating bit 0 sets count direction
// - reserved operating bits; vendor bits 12-15
// - preset write forces output immediately
// - 32-bit objects least significant byte first
// - position object feeds the transmit object
// - step in sub-index 1, low half
// - nonzero timer sends every N ms
// - timer lost at restart, rewrite
// - start command begins cyclic sending
// - status word mirrors count direction
// - active step readable, upper half zero
// - alarm sticky until cleared and good
// - alarm byte 0 bit assignment
module dpo_position_out
  import dpo_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // object access
  input  wire logic        obj_req_i,
  input  wire logic        obj_wr_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [7:0]  obj_sub_i,
  input  wire logic [31:0] obj_wdata_i,
  output logic             obj_ack_o,
  output logic             obj_err_o,
  output logic [31:0]      obj_rdata_o,
  // network management
  input  wire logic        nmt_start_i,
  input  wire logic        nmt_stop_i,
  // raw distance in hundredths of a millimetre
  input  wire logic        meas_valid_i,
  input  wire logic [31:0] meas_dist_i,
  // malfunction conditions and acknowledge
  input  wire logic [ALARM_BITS-1:0] alarm_cond_i,
  input  wire logic        alarm_ack_i,
  // process data
  output logic             pdo_tx_o,
  output logic [31:0]      pdo_pos_o,
  output logic [31:0]      position_o
);

  dpo_div_if div_bus ();

  dpo_divider u_div (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .dv       (div_bus)
  );

  logic [7:0]  res_sel_reg;
  logic [15:0] oper_reg;
  logic [31:0] preset_reg;
  logic [15:0] free_step_reg;
  logic [15:0] cyclic_reg;
  logic [31:0] offset_reg;
  logic [31:0] scaled_reg;
  logic [31:0] pos_reg;
  logic [ALARM_BITS-1:0] alarm_reg;
  logic        obj_ack_reg;
  logic        obj_err_reg;
  logic [31:0] obj_rdata_reg;
  logic        oper_run_reg;
  logic [31:0] ms_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic        pdo_tx_reg;
  logic [31:0] pdo_pos_reg;
  logic        ms_tick;
  logic [15:0] active_step;
  logic        wr;
  logic        rd;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [31:0] pos_next;
  logic        count_down;
  logic        wr_res;
  logic        wr_oper;
  logic        wr_preset;
  logic        wr_step;
  logic        wr_cyclic;
  logic [31:0] scaled_now;
  logic        start_cmd;
  logic        cyclic_on;
  logic        period_due;
  logic        send_now;

  assign wr         = obj_req_i && obj_wr_i;
  assign rd         = obj_req_i && !obj_wr_i;
  assign count_down = oper_reg[DIR_BIT];

  // step of the selected resolution in hundredths of a millimetre
  always_comb begin
    unique case (res_sel_reg[2:0])
      RES_CM:       active_step = STEP_CM;
      RES_MM:       active_step = STEP_MM;
      RES_TENTH_MM: active_step = STEP_TENTH_MM;
      RES_HUND_MM:  active_step = STEP_HUND_MM;
      RES_INCH:     active_step = STEP_INCH;
      RES_TENTH_IN: active_step = STEP_TENTH_IN;
      default:      active_step = free_step_reg;
    endcase
  end

  // write acceptance: only writable objects with values in range
  always_comb begin
    wr_ok = 1'b0;
    unique case (obj_index_i)
      IDX_RESOLUTION: wr_ok = (obj_wdata_i[31:3] == 29'h0) && (obj_wdata_i[2:0] != 3'b111);
      IDX_OPER_PARAM: wr_ok = (obj_wdata_i[31:16] == 16'h0000);
      IDX_PRESET:     wr_ok = 1'b1;
      IDX_FREE_STEP:  wr_ok = (obj_sub_i == SUB_STEP) && (obj_wdata_i[31:16] == 16'h0000)
                              && (obj_wdata_i[15:0] != 16'h0000);
      IDX_CYCLIC:     wr_ok = (obj_wdata_i[31:16] == 16'h0000);
      default:        wr_ok = 1'b0;
    endcase
  end

  // read mux; bit i of the word is byte i/8, low byte first on the wire
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (obj_index_i)
      IDX_RESOLUTION:  rd_val = {24'h00_0000, res_sel_reg};
      IDX_OPER_PARAM:  rd_val = {16'h0000, oper_reg};
      IDX_PRESET:      rd_val = preset_reg;
      IDX_POSITION:    rd_val = pos_reg;
      IDX_FREE_STEP:   rd_val = (obj_sub_i == SUB_COUNT) ? {24'h00_0000, FREE_STEP_ENTRIES}
                                                         : {16'h0000, free_step_reg};
      IDX_CYCLIC:      rd_val = {16'h0000, cyclic_reg};
      IDX_OPER_STATUS: rd_val = {16'h0000, oper_reg};
      IDX_ACTIVE_STEP: rd_val = {16'h0000, active_step};
      IDX_ALARMS:      rd_val = {27'h000_0000, alarm_reg};
      default:         rd_hit = 1'b0;
    endcase
  end

  // object access answer, one cycle after the request
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      obj_ack_reg <= 1'b0;
      obj_err_reg <= 1'b0;
    end else begin
      obj_ack_reg <= obj_req_i;
      obj_err_reg <= (wr && !wr_ok) || (rd && !rd_hit);
    end
  end

  // read data holds until the next successful read
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      obj_rdata_reg <= 32'h0000_0000;
    end else if (rd && rd_hit) begin
      obj_rdata_reg <= rd_val;
    end
  end

  // write strobes, only for accepted values
  assign wr_res    = wr && wr_ok && (obj_index_i == IDX_RESOLUTION);
  assign wr_oper   = wr && wr_ok && (obj_index_i == IDX_OPER_PARAM);
  assign wr_preset = wr && wr_ok && (obj_index_i == IDX_PRESET);
  assign wr_step   = wr && wr_ok && (obj_index_i == IDX_FREE_STEP);
  assign wr_cyclic = wr && wr_ok && (obj_index_i == IDX_CYCLIC);

  // resolution selector
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_sel_reg <= RESOLUTION_RST;
    end else if (wr_res) begin
      res_sel_reg <= obj_wdata_i[7:0];
    end
  end

  // operating word; only direction and vendor bits are kept
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oper_reg <= OPER_RST;
    end else if (wr_oper) begin
      oper_reg <= obj_wdata_i[15:0] & OPER_WR_MASK;
    end
  end

  // free measuring step
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      free_step_reg <= FREE_STEP_RST;
    end else if (wr_step) begin
      free_step_reg <= obj_wdata_i[15:0];
    end
  end

  // cyclic timer is volatile: back to zero at every reset
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cyclic_reg <= CYCLIC_RST;
    end else if (wr_cyclic) begin
      cyclic_reg <= obj_wdata_i[15:0];
    end
  end

  // preset value as last written
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      preset_reg <= PRESET_RST;
    end else if (wr_preset) begin
      preset_reg <= obj_wdata_i;
    end
  end

  // scale each distance that arrives while the divider is idle by the active step
  assign div_bus.start    = meas_valid_i && !div_bus.busy;
  assign div_bus.dividend = meas_dist_i;
  assign div_bus.divisor  = active_step;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scaled_reg <= 32'h0000_0000;
    end else if (div_bus.done) begin
      scaled_reg <= div_bus.quotient;
    end
  end

  // a distance landing with a preset write must enter the offset
  assign scaled_now = div_bus.done ? div_bus.quotient : scaled_reg;

  // output position: offset plus or minus scaled distance
  always_comb begin
    if (div_bus.done) begin
      pos_next = count_down ? offset_reg - div_bus.quotient : offset_reg + div_bus.quotient;
    end else begin
      pos_next = count_down ? offset_reg - scaled_reg : offset_reg + scaled_reg;
    end
  end

  // offset chosen so the output equals the preset at the moment of writing
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_reg <= 32'h0000_0000;
    end else if (wr_preset) begin
      offset_reg <= count_down ? obj_wdata_i + scaled_now : obj_wdata_i - scaled_now;
    end
  end

  // a direction change keeps the offset, so the output may jump; preset again after it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_reg <= 32'h0000_0000;
    end else if (wr_preset) begin
      pos_reg <= obj_wdata_i;
    end else begin
      pos_reg <= pos_next;
    end
  end

  assign position_o = pos_reg;

  // millisecond tick; restarted by the start command so the first period is whole
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (ms_tick || (start_cmd && !oper_run_reg)) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end

  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  // node state
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oper_run_reg <= 1'b0;
    end else if (nmt_stop_i) begin
      oper_run_reg <= 1'b0;
    end else if (nmt_start_i) begin
      oper_run_reg <= 1'b1;
    end
  end

  // stop wins over start when both arrive together
  assign start_cmd = nmt_start_i && !nmt_stop_i;
  assign cyclic_on = (cyclic_reg != 16'h0000);

  // cyclic transmit period counter
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_cnt_reg <= 16'h0000;
    end else if (!oper_run_reg || !cyclic_on) begin
      period_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      if (period_due) begin
        period_cnt_reg <= 16'h0000;
      end else begin
        period_cnt_reg <= period_cnt_reg + 16'h0001;
      end
    end
  end

  assign period_due = (period_cnt_reg >= cyclic_reg - 16'h0001);
  // first send on the start command, then once per elapsed period
  assign send_now   = (!oper_run_reg && start_cmd && cyclic_on)
                      || (oper_run_reg && cyclic_on && ms_tick && period_due);

  // send strobe and the position it carries
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pdo_tx_reg  <= 1'b0;
      pdo_pos_reg <= 32'h0000_0000;
    end else begin
      pdo_tx_reg <= send_now;
      if (send_now) begin
        pdo_pos_reg <= pos_reg;
      end
    end
  end

  // sticky alarms; a live condition wins over the acknowledge
  generate
    for (genvar i = 0; i < ALARM_BITS; i++) begin : g_alarm
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          alarm_reg[i] <= 1'b0;
        end else if (alarm_cond_i[i]) begin
          alarm_reg[i] <= 1'b1;
        end else if (alarm_ack_i) begin
          alarm_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign obj_ack_o   = obj_ack_reg;
  assign obj_err_o   = obj_err_reg;
  assign obj_rdata_o = obj_rdata_reg;
  assign pdo_tx_o    = pdo_tx_reg;
  assign pdo_pos_o   = pdo_pos_reg;

endmodule : dpo_position_out

// ==== pkg/dpo_pkg.sv ====
package dpo_pkg;

  // object indices and sub-indices
  localparam logic [15:0] IDX_RESOLUTION  = 16'h2007;
  localparam logic [15:0] IDX_OPER_PARAM  = 16'h6000;
  localparam logic [15:0] IDX_PRESET      = 16'h6003;
  localparam logic [15:0] IDX_POSITION    = 16'h6004;
  localparam logic [15:0] IDX_FREE_STEP   = 16'h6005;
  localparam logic [15:0] IDX_CYCLIC      = 16'h6200;
  localparam logic [15:0] IDX_OPER_STATUS = 16'h6500;
  localparam logic [15:0] IDX_ACTIVE_STEP = 16'h6501;
  localparam logic [15:0] IDX_ALARMS      = 16'h6503;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_STEP        = 8'h01;
  localparam logic [7:0]  FREE_STEP_ENTRIES = 8'h01;

  // field layout of the operating parameter word
  localparam int          DIR_BIT        = 0;
  localparam logic [15:0] OPER_WR_MASK   = 16'hF001;

  // reset values
  localparam logic [7:0]  RESOLUTION_RST = 8'h01;
  localparam logic [15:0] OPER_RST       = 16'h0000;
  localparam logic [15:0] FREE_STEP_RST  = 16'h0064;
  localparam logic [15:0] CYCLIC_RST     = 16'h0000;
  localparam logic [31:0] PRESET_RST     = 32'h0000_0000;

  // step sizes in hundredths of a millimetre per resolution code
  localparam logic [15:0] STEP_CM        = 16'h03E8;
  localparam logic [15:0] STEP_MM        = 16'h0064;
  localparam logic [15:0] STEP_TENTH_MM  = 16'h000A;
  localparam logic [15:0] STEP_HUND_MM   = 16'h0001;
  localparam logic [15:0] STEP_INCH      = 16'h09EC;
  localparam logic [15:0] STEP_TENTH_IN  = 16'h00FE;

  typedef enum logic [2:0] {
    RES_CM       = 3'b000,
    RES_MM       = 3'b001,
    RES_TENTH_MM = 3'b010,
    RES_HUND_MM  = 3'b011,
    RES_INCH     = 3'b100,
    RES_TENTH_IN = 3'b101,
    RES_FREE     = 3'b110
  } dpo_res_t;

  localparam int ALARM_BITS = 5;

  // timing
  localparam int CLK_HZ        = 250_000_000;
  localparam int MS_PER_SEC    = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;

endpackage : dpo_pkg

// ==== pkg/dpo_div_if.sv ====
`timescale 1ns/10ps
interface dpo_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        done;
  logic [31:0] quotient;
  logic        busy;

  modport req (output start, output dividend, output divisor, input done, input quotient, input busy);
  modport div (input start, input dividend, input divisor, output done, output quotient, output busy);
endinterface : dpo_div_if

// ==== rtl/dpo_divider.sv ====
`timescale 1ns/10ps
// restoring divider, one quotient bit per clock
module dpo_divider (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  dpo_div_if.div    dv
);
  logic [31:0] quo_reg;
  logic [16:0] rem_reg;
  logic [15:0] dvs_reg;
  logic [5:0]  cnt_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [16:0] trial;

  assign trial       = {rem_reg[15:0], quo_reg[31]} - {1'b0, dvs_reg};
  assign dv.quotient = quo_reg;
  assign dv.busy     = busy_reg;
  assign dv.done     = done_reg;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      quo_reg  <= 32'h0000_0000;
      rem_reg  <= 17'h0_0000;
      dvs_reg  <= 16'h0000;
      cnt_reg  <= 6'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && dv.start) begin
        quo_reg  <= dv.dividend;
        rem_reg  <= 17'h0_0000;
        dvs_reg  <= dv.divisor;
        cnt_reg  <= 6'h20;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (!trial[16]) begin
          rem_reg <= trial;
          quo_reg <= {quo_reg[30:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[15:0], quo_reg[31]};
          quo_reg <= {quo_reg[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule : dpo_divider

// ==== dv/dpo_fb_master.sv ====
`timescale 1ns/10ps
// network master side of the object access port
module dpo_fb_master (
  input  wire logic        mclk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] rdata_i,
  output logic             req_o,
  output logic             wr_o,
  output logic [15:0]      index_o,
  output logic [7:0]       sub_o,
  output logic [31:0]      wdata_o
);
  initial begin
    req_o   = 1'b0;
    wr_o    = 1'b0;
    index_o = 16'h0000;
    sub_o   = 8'h00;
    wdata_o = 32'h0000_0000;
  end

  // whole word per access, byte 0 in bits 7:0
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge mclk_i);
    #1;
    req_o   = 1'b1;
    wr_o    = w;
    index_o = idx;
    sub_o   = sub;
    wdata_o = d;
    @(posedge mclk_i);
    #1;
    rd      = rdata_i;
    er      = (ack_i === 1'b1) ? err_i : 1'bx;
    req_o   = 1'b0;
    // idle lines carry no stale copy of the request
    index_o = ~idx;
    sub_o   = ~sub;
    wdata_o = ~d;
  endtask : acc
endmodule : dpo_fb_master

// ==== dv/dpo_position_out_sva.sv ====
`timescale 1ns/10ps
module dpo_position_out_sva
  import dpo_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input wire logic                  mclk_i,
  input wire logic                  resetn_i,
  input wire logic                  obj_req_i,
  input wire logic                  obj_wr_i,
  input wire logic [15:0]           obj_index_i,
  input wire logic [7:0]            obj_sub_i,
  input wire logic [31:0]           obj_wdata_i,
  input wire logic                  obj_ack_o,
  input wire logic                  obj_err_o,
  input wire logic [31:0]           obj_rdata_o,
  input wire logic                  nmt_start_i,
  input wire logic                  nmt_stop_i,
  input wire logic                  meas_valid_i,
  input wire logic [31:0]           meas_dist_i,
  input wire logic [ALARM_BITS-1:0] alarm_cond_i,
  input wire logic                  alarm_ack_i,
  input wire logic                  pdo_tx_o,
  input wire logic [31:0]           pdo_pos_o,
  input wire logic [31:0]           position_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire logic wr_q = obj_req_i && obj_wr_i;
  wire logic rd_q = obj_req_i && !obj_wr_i;
  wire logic ro_i = obj_index_i inside {IDX_POSITION, IDX_OPER_STATUS, IDX_ACTIVE_STEP, IDX_ALARMS};

  AST_ACK_NEXT: assert property (obj_req_i |=> obj_ack_o) else $error("no ack after request");
  AST_ACK_ONLY: assert property (!obj_req_i |=> !obj_ack_o && !obj_err_o) else $error("stray ack");
  AST_PRESET_NOW: assert property (wr_q && obj_index_i == IDX_PRESET |=>
    !obj_err_o && position_o == $past(obj_wdata_i)) else $error("preset not applied");
  AST_RO_REFUSE: assert property (wr_q && ro_i |=> obj_err_o) else $error("read-only write taken");
  AST_RES_RANGE: assert property (wr_q && obj_index_i == IDX_RESOLUTION |=>
    obj_err_o == ($past(obj_wdata_i) > 32'd6)) else $error("resolution check wrong");
  AST_STEP_RANGE: assert property (wr_q && obj_index_i == IDX_FREE_STEP && obj_sub_i == SUB_STEP |=>
    obj_err_o == ($past(obj_wdata_i) == 0 || $past(obj_wdata_i) > 32'd65535)) else $error("step check wrong");
  AST_STATUS_RSV: assert property (rd_q && obj_index_i == IDX_OPER_STATUS |=>
    !obj_err_o && obj_rdata_o[31:16] == 16'h0000 && obj_rdata_o[11:1] == 11'h000) else $error("status bits");
  AST_STEP_UPPER: assert property (rd_q && obj_index_i == IDX_ACTIVE_STEP |=>
    !obj_err_o && obj_rdata_o[31:16] == 16'h0000) else $error("step upper half");
  AST_TX_PULSE: assert property (pdo_tx_o |=> !pdo_tx_o) else $error("send pulse too long");

  cover property (wr_q && obj_index_i == IDX_PRESET);
  cover property (pdo_tx_o);
  cover property (obj_err_o);
endmodule : dpo_position_out_sva

bind dpo_position_out dpo_position_out_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (.*);

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import dpo_pkg::*;
  localparam int MSC = 10;
  logic                  mclk_i, resetn_i, nmt_start_i, nmt_stop_i, meas_valid_i, alarm_ack_i;
  logic                  obj_req_i, obj_wr_i, obj_ack_o, obj_err_o, pdo_tx_o, er;
  logic [ALARM_BITS-1:0] alarm_cond_i;
  logic [15:0]           obj_index_i, fs;
  logic [7:0]            obj_sub_i;
  logic [31:0]           obj_wdata_i, obj_rdata_o, pdo_pos_o, position_o, meas_dist_i, rd, p, d0, d1, e;
  logic [15:0]           steps [6] = '{STEP_CM, STEP_MM, STEP_TENTH_MM, STEP_HUND_MM, STEP_INCH, STEP_TENTH_IN};
  logic [15:0]           ro [4] = '{IDX_POSITION, IDX_OPER_STATUS, IDX_ACTIVE_STEP, IDX_ALARMS};
  int                    miscompares, compares, seed, t;

  dpo_position_out #(.MS_CYCLES(MSC)) i_dut (.*);
  dpo_fb_master i_mst (.mclk_i(mclk_i), .ack_i(obj_ack_o), .err_i(obj_err_o), .rdata_i(obj_rdata_o),
    .req_o(obj_req_i), .wr_o(obj_wr_i), .index_o(obj_index_i), .sub_o(obj_sub_i), .wdata_o(obj_wdata_i));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] x, input logic [31:0] a);
    compares++;
    if (a !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, x, a);
    end
  endtask : chk
  task automatic chk_bit(input logic x, input logic a);
    compares++;
    if (a !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, x, a);
    end
  endtask : chk_bit
  function automatic logic [31:0] exp_pos(input logic [31:0] pr, input logic [31:0] a, input logic [31:0] b,
                                          input int down);
    exp_pos = down ? pr + a / STEP_MM - b / STEP_MM : pr - a / STEP_MM + b / STEP_MM;
  endfunction : exp_pos
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic x);
    i_mst.acc(1'b1, i, s, d, rd, er);
    chk_bit(x, er);
  endtask : wr
  task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
    i_mst.acc(1'b0, i, s, 32'h0000_0000, rd, er);
    chk_bit(1'b0, er);
    chk(x, rd);
  endtask : rdc
  // result lands 33 cycles after the pulse cycle
  task automatic meas(input logic [31:0] d);
    @(posedge mclk_i);
    #1 meas_valid_i = 1'b1;
    meas_dist_i = d;
    @(posedge mclk_i);
    #1 meas_valid_i = 1'b0;
    meas_dist_i = ~d;
    repeat (33) @(posedge mclk_i);
    #1;
  endtask : meas
  task automatic pulse(ref logic s);
    @(posedge mclk_i);
    #1 s = 1'b1;
    @(posedge mclk_i);
    #1 s = 1'b0;
  endtask : pulse
  task automatic wait_tx(input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (pdo_tx_o !== 1'b1 && n < lim);
  endtask : wait_tx
  task automatic rst;
    #1 resetn_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 resetn_i = 1'b1;
  endtask : rst
  task automatic print_verdict;
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    seed = 95963;
    {miscompares, compares} = '0;
    {resetn_i, nmt_start_i, nmt_stop_i, meas_valid_i, alarm_ack_i, alarm_cond_i, meas_dist_i} = '0;
    rst();
    rdc(IDX_RESOLUTION, SUB_COUNT, 32'h0000_0001);
    rdc(IDX_OPER_PARAM, SUB_COUNT, 32'h0000_0000);
    rdc(IDX_FREE_STEP, SUB_STEP, 32'h0000_0064);
    rdc(IDX_FREE_STEP, SUB_COUNT, {24'h00_0000, FREE_STEP_ENTRIES});
    wr(IDX_FREE_STEP, SUB_STEP, 32'h0000_0000, 1'b1);
    wr(IDX_FREE_STEP, SUB_STEP, 32'h0001_0000, 1'b1);
    fs = 16'($random(seed));
    if (fs == 16'h0000) fs = 16'hFFFF;
    wr(IDX_FREE_STEP, SUB_STEP, {16'h0000, fs}, 1'b0);
    rdc(IDX_FREE_STEP, SUB_STEP, {16'h0000, fs});
    for (int c = 0; c < 8; c++) begin
      wr(IDX_RESOLUTION, SUB_COUNT, 32'(c), c > 6);
      if (c < 7) rdc(IDX_ACTIVE_STEP, SUB_COUNT, {16'h0000, (c == 6) ? fs : steps[c]});
    end
    wr(IDX_RESOLUTION, SUB_COUNT, 32'h0000_0001, 1'b0);
    wr(IDX_OPER_PARAM, SUB_COUNT, 32'h0001_0000, 1'b1);
    wr(IDX_OPER_PARAM, SUB_COUNT, 32'h0000_FFFF, 1'b0);
    rdc(IDX_OPER_PARAM, SUB_COUNT, {16'h0000, OPER_WR_MASK});
    rdc(IDX_OPER_STATUS, SUB_COUNT, {16'h0000, OPER_WR_MASK});
    foreach (ro[i]) wr(ro[i], SUB_COUNT, 32'($random(seed)), 1'b1);
    i_mst.acc(1'b0, 16'h1234, SUB_COUNT, 32'h0000_0000, rd, er);
    chk_bit(1'b1, er);
    // preset against a stored scaled value, both count directions
    for (int dir = 0; dir < 2; dir++) begin
      wr(IDX_OPER_PARAM, SUB_COUNT, 32'(dir), 1'b0);
      d0 = 32'($random(seed)) & 32'h000F_FFFF;
      d1 = 32'($random(seed)) & 32'h000F_FFFF;
      meas(d0);
      p = 32'h0010_0000 + (32'($random(seed)) & 32'h0000_FFFF);
      wr(IDX_PRESET, SUB_COUNT, p, 1'b0);
      chk(p, position_o);
      meas(d1);
      e = exp_pos(p, d0, d1, dir);
      chk(e, position_o);
      rdc(IDX_POSITION, SUB_COUNT, e);
    end
    wr(IDX_CYCLIC, SUB_COUNT, 32'h0000_0003, 1'b0);
    pulse(nmt_start_i);
    chk_bit(1'b1, pdo_tx_o);
    chk(e, pdo_pos_o);
    wait_tx(40, t);
    chk(3 * MSC, t);
    wait_tx(40, t);
    chk(3 * MSC, t);
    pulse(nmt_stop_i);
    wait_tx(100, t);
    chk(100, t);
    wr(IDX_CYCLIC, SUB_COUNT, 32'h0000_0000, 1'b0);
    pulse(nmt_start_i);
    wait_tx(50, t);
    chk(50, t);
    pulse(nmt_stop_i);
    wr(IDX_CYCLIC, SUB_COUNT, 32'h0000_0001, 1'b0);
    pulse(nmt_start_i);
    chk_bit(1'b1, pdo_tx_o);
    wait_tx(20, t);
    chk(MSC, t);
    wr(IDX_CYCLIC, SUB_COUNT, 32'h0000_0002, 1'b0);
    rst();
    rdc(IDX_CYCLIC, SUB_COUNT, 32'h0000_0000);
    pulse(nmt_start_i);
    chk_bit(1'b0, pdo_tx_o);
    for (int b = 0; b < ALARM_BITS; b++) begin
      alarm_cond_i = ALARM_BITS'(1 << b);
      rdc(IDX_ALARMS, SUB_COUNT, 32'(1 << b));
      alarm_ack_i = 1'b1;
      rdc(IDX_ALARMS, SUB_COUNT, 32'(1 << b));
      {alarm_cond_i, alarm_ack_i} = '0;
      rdc(IDX_ALARMS, SUB_COUNT, 32'(1 << b));
      alarm_ack_i = 1'b1;
      rdc(IDX_ALARMS, SUB_COUNT, 32'h0000_0000);
      alarm_ack_i = 1'b0;
    end
    print_verdict();
  end
endmodule : tb
